// File: hdl/tec_timer.sv
// Register access over Avalon-MM and the placing of the registers were decided locally.
`timescale 1ns/1ns
module tec_timer (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [3:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic ext_timer_pin_i,
    input wire logic low_freq_crystal_clock_i,
    input wire logic pwm_enable_i,
    input wire logic sleep_i,
    output logic overflow_o,
    output logic wakeup_o,
    output logic timer_base_clock_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic lxt_s1;
        logic lxt_s2;
        logic lxt_prev;
        logic [7:0] ctrl;
        logic [7:0] preload;
        logic [7:0] count;
        logic [7:0] t1_count;
        tec_pkg::tec_cap_e cap;
        logic ack;
        logic [31:0] rdata;
        logic ovf;
        logic wake;
        logic tp;
    } tec_st_s;

    tec_st_s st;
    tec_st_s next_st;

    tec_pkg::tec_mode_e mode;
    logic en;
    logic edge_sel;
    logic pin_rise;
    logic pin_fall;
    logic lxt_fall;
    logic int_tick;
    logic div_tick;
    logic evt_edge;
    logic start_edge;
    logic stop_edge;
    logic inc;
    logic req;
    logic take;
    logic wr_ctrl;
    logic wr_cnt;
    logic wr_t1;
    logic [31:0] rd_mux;

    // ****************************************************************
    // Field decode
    // ****************************************************************
    // mode field decode
    assign mode = tec_pkg::tec_mode_e'(
        st.ctrl[tec_pkg::CTRL_MODE_HI:tec_pkg::CTRL_MODE_LO]);
    assign en = st.ctrl[tec_pkg::CTRL_ENABLE];
    assign edge_sel = st.ctrl[tec_pkg::CTRL_EDGE];

    // ****************************************************************
    // Edge detection on synchronised inputs
    // ****************************************************************
    // single-cycle edge pulses
    assign pin_rise = st.pin_s2 & ~st.pin_prev;
    assign pin_fall = ~st.pin_s2 & st.pin_prev;
    // Crystal clock is far slower than ref_clk, so it is sampled
    assign lxt_fall = ~st.lxt_s2 & st.lxt_prev;

    // ****************************************************************
    // Internal timer clock select and prescaler
    // ****************************************************************
    // clock source select
    // PWM override
    // The system clock stops in sleep, so the internal tick does too
    assign int_tick = ~sleep_i &
        ((pwm_enable_i | ~st.ctrl[tec_pkg::CTRL_CLK_SRC]) ? 1'b1 : lxt_fall);

    tec_prescaler #(
        .DIV_W(tec_pkg::PSC_DIV_W),
        .SEL_W(tec_pkg::PSC_SEL_W)
    ) u_presc (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .tick_i(int_tick),
        .sel_i(st.ctrl[tec_pkg::CTRL_PSC_HI:tec_pkg::CTRL_PSC_LO]),
        .tick_o(div_tick)
    );

    // ****************************************************************
    // Count qualification
    // ****************************************************************
    // event edge choice
    assign evt_edge = edge_sel ? pin_fall : pin_rise;
    assign start_edge = edge_sel ? pin_rise : pin_fall;
    assign stop_edge = edge_sel ? pin_fall : pin_rise;

    always_comb begin
        case (mode)
            tec_pkg::MODE_EVENT: inc = en & evt_edge;
            tec_pkg::MODE_TIMER: inc = en & div_tick;
            tec_pkg::MODE_PWC: inc = en & (st.cap == tec_pkg::CAP_RUN) &
                                     ~stop_edge & div_tick;
            default: inc = 1'b0;
        endcase
    end

    // ****************************************************************
    // Avalon-MM slave: one wait cycle, then the answer
    // ****************************************************************
    assign req = read_i | write_i;
    assign waitrequest_o = req & ~st.ack;
    assign take = req & st.ack;
    assign wr_ctrl = write_i & take & byteenable_i[0] &
                     (address_i == tec_pkg::OFS_CONTROL);
    assign wr_cnt = write_i & take & byteenable_i[0] &
                    (address_i == tec_pkg::OFS_COUNT);
    assign wr_t1 = write_i & take & byteenable_i[0] &
                   (address_i == tec_pkg::OFS_T1_COUNT);

    always_comb begin
        case (address_i)
            tec_pkg::OFS_CONTROL: rd_mux = {24'h000000, st.ctrl};
            tec_pkg::OFS_COUNT: rd_mux = {24'h000000, st.count};
            tec_pkg::OFS_T1_COUNT: rd_mux = {24'h000000, st.t1_count};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.ack = req & ~st.ack;
        next_st.pin_s1 = ext_timer_pin_i;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_prev = st.pin_s2;
        next_st.lxt_s1 = low_freq_crystal_clock_i;
        next_st.lxt_s2 = st.lxt_s1;
        next_st.lxt_prev = st.lxt_s2;
        next_st.ovf = 1'b0;
        next_st.wake = 1'b0;
        next_st.tp = int_tick;
        if (read_i && !st.ack) begin
            next_st.rdata = rd_mux;
        end

        // Preload first, so an overflow in the same cycle takes it
        if (wr_cnt) begin
            next_st.preload = writedata_i[7:0];
            if (!en) begin
                next_st.count = writedata_i[7:0];
            end
        end
        if (wr_t1) begin
            next_st.t1_count = writedata_i[7:0];
        end

        if (inc) begin
            if (st.count == tec_pkg::COUNT_FULL) begin
                next_st.count = next_st.preload;
                next_st.ovf = 1'b1;
                next_st.wake = (mode == tec_pkg::MODE_EVENT);
            end else begin
                next_st.count = st.count + 8'h01;
            end
        end

        if (mode == tec_pkg::MODE_PWC && en) begin
            case (st.cap)
                tec_pkg::CAP_IDLE: begin
                    if (start_edge) begin
                        next_st.cap = tec_pkg::CAP_RUN;
                    end
                end
                tec_pkg::CAP_RUN: begin
                    if (stop_edge) begin
                        next_st.cap = tec_pkg::CAP_IDLE;
                        next_st.ctrl[tec_pkg::CTRL_ENABLE] = 1'b0;
                    end
                end
                default: next_st.cap = tec_pkg::CAP_IDLE;
            endcase
        end else begin
            next_st.cap = tec_pkg::CAP_IDLE;
        end

        // Software write wins over the self-clear of the enable
        if (wr_ctrl) begin
            next_st.ctrl = writedata_i[7:0];
        end

        if (!resetn_i) begin
            next_st = '0;
            next_st.ctrl = tec_pkg::CTRL_RESET;
            next_st.cap = tec_pkg::CAP_IDLE;
            next_st.preload = st.preload;
            next_st.count = st.count;
            next_st.t1_count = st.t1_count;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || ce_i) begin
            st <= next_st;
        end
    end

    assign readdata_o = st.rdata;
    assign overflow_o = st.ovf;
    assign wakeup_o = st.wake;
    assign timer_base_clock_o = st.tp;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_count_incr:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && inc && st.count != 8'hFF && !wr_cnt)
        |=> (st.count == $past(st.count) + 8'h01) && !st.ovf)
    else $error("counter did not step by one");

    a_mode_none:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && mode == tec_pkg::MODE_NONE && !wr_cnt)
        |=> $stable(st.count) && !st.ovf)
    else $error("counter moved with no mode selected");

    a_ovf_reload:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && inc && st.count == 8'hFF && !wr_cnt)
        |=> st.ovf && (st.count == $past(st.preload)) ##1 !st.ovf)
    else $error("overflow did not flag and reload");

    a_write_stopped:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && wr_cnt && !en)
        |=> (st.count == $past(writedata_i[7:0])) &&
            (st.preload == $past(writedata_i[7:0])))
    else $error("stopped write did not load counter");

    a_write_running:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && wr_cnt && en && !inc)
        |=> (st.count == $past(st.count)) &&
            (st.preload == $past(writedata_i[7:0])))
    else $error("running write touched live counter");

    a_read_count:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && read_i && !st.ack && address_i == tec_pkg::OFS_COUNT)
        |=> (readdata_o[7:0] == $past(st.count)) && !waitrequest_o)
    else $error("count read returned wrong value");

    a_gate_off:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && !en && !wr_cnt)
        |=> $stable(st.count))
    else $error("counter moved while disabled");

    a_pwc_armed:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && mode == tec_pkg::MODE_PWC && en &&
         st.cap == tec_pkg::CAP_IDLE && !wr_cnt)
        |=> st.count == $past(st.count))
    else $error("capture counted before its start edge");

    a_pwc_stop:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && mode == tec_pkg::MODE_PWC && en && !wr_ctrl &&
         st.cap == tec_pkg::CAP_RUN && stop_edge)
        |=> !st.ctrl[tec_pkg::CTRL_ENABLE] &&
            (st.cap == tec_pkg::CAP_IDLE))
    else $error("capture stop did not clear enable");

    a_event_edge:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (mode == tec_pkg::MODE_EVENT && en && !evt_edge)
        |-> !inc)
    else $error("event count without selected edge");

    a_pwm_clock:
    assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (ce_i && pwm_enable_i && !sleep_i)
        |=> timer_base_clock_o)
    else $error("PWM enabled but timer clock not system");

    a_reset_ctrl:
    assert property (@(posedge ref_clk_i)
        !resetn_i |=> st.ctrl == 8'h08)
    else $error("control register reset value wrong");

endmodule

// File: hdl/tec_pkg.sv
package tec_pkg;

    // ****************************************************************
    // Register map (byte addresses on the Avalon-MM slave)
    // ****************************************************************
    localparam int unsigned ADDR_W = 4;
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_COUNT = 4'h4;
    localparam logic [3:0] OFS_T1_COUNT = 4'h8;

    // ****************************************************************
    // Control register fields
    // ****************************************************************
    localparam int unsigned CNT_W = 8;
    localparam int unsigned CTRL_MODE_HI = 7;
    localparam int unsigned CTRL_MODE_LO = 6;
    localparam int unsigned CTRL_CLK_SRC = 5;
    localparam int unsigned CTRL_ENABLE = 4;
    localparam int unsigned CTRL_EDGE = 3;
    localparam int unsigned CTRL_PSC_HI = 2;
    localparam int unsigned CTRL_PSC_LO = 0;
    localparam int unsigned PSC_SEL_W = 3;
    localparam logic [7:0] CTRL_RESET = 8'h08;
    localparam logic [7:0] COUNT_FULL = 8'hFF;

    // ****************************************************************
    // Prescaler: divide by up to 2**7 = 128
    // ****************************************************************
    localparam int unsigned PSC_DIV_W = 7;

    // ****************************************************************
    // Modes and capture states
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_EVENT = 2'h1,
        MODE_TIMER = 2'h2,
        MODE_PWC = 2'h3
    } tec_mode_e;

    typedef enum logic [0:0] {
        CAP_IDLE = 1'h0,
        CAP_RUN = 1'h1
    } tec_cap_e;

endpackage

// File: hdl/tec_prescaler.sv
`timescale 1ns/1ns
module tec_prescaler #(
    parameter int unsigned DIV_W = tec_pkg::PSC_DIV_W,
    parameter int unsigned SEL_W = tec_pkg::PSC_SEL_W
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic tick_i,
    input wire logic [SEL_W-1:0] sel_i,
    output logic tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] div;
    } tec_psc_s;

    tec_psc_s st;
    tec_psc_s next_st;
    logic [DIV_W-1:0] low_full;

    // ****************************************************************
    // Divided tick fires when bit sel-1 falls, i.e. all low bits full
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < DIV_W; i = i + 1) begin : g_full
            assign low_full[i] = (i >= int'(sel_i)) | st.div[i];
        end
    endgenerate

    assign tick_o = tick_i & (&low_full);

    always_comb begin
        next_st = st;
        if (tick_i) begin
            next_st.div = st.div + {{(DIV_W-1){1'b0}}, 1'b1};
        end
        if (!resetn_i) begin
            next_st = '0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || ce_i) begin
            st <= next_st;
        end
    end

endmodule

// File: verification/tec_pin_source.sv
`timescale 1ns/1ns
// ****************************************************************
// External source on the timer pin: toggles the line a given
// number of times, each level held for half_i clock cycles
// ****************************************************************
module tec_pin_source (
    input wire logic ref_clk_i,
    input wire logic start_i,
    input wire logic [7:0] toggles_i,
    input wire logic [7:0] half_i,
    output logic pin_o,
    output logic busy_o
);
    logic [7:0] left;
    logic [7:0] cnt;

    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        left = 8'h00;
        cnt = 8'h00;
    end

    // Every level lasts half_i cycles, so short pulses never occur
    always @(posedge ref_clk_i) begin
        if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            left <= toggles_i;
            cnt <= half_i;
        end else if (busy_o) begin
            if (cnt > 8'h01) begin
                cnt <= cnt - 8'h01;
            end else begin
                pin_o <= ~pin_o;
                cnt <= half_i;
                left <= left - 8'h01;
                if (left == 8'h01) begin
                    busy_o <= 1'b0;
                end
            end
        end
    end
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] address_i = 4'h0;
    logic read_i = 1'b0;
    logic write_i = 1'b0;
    logic [31:0] writedata_i = 32'h0;
    logic [3:0] byteenable_i = 4'h0;
    logic [31:0] readdata_o;
    logic waitrequest_o, pin, overflow_o, wakeup_o, src_busy;
    logic lfxt = 1'b0, pwm_en = 1'b0, sleep = 1'b0, src_start = 1'b0;
    logic [7:0] src_toggles = 8'h00;
    logic [31:0] d;
    int mismatches = 0, num_checks = 0, ovf_cnt = 0, wake_cnt = 0;
    int xtal_div = 0, tbc_cnt = 0;
    logic ce = 1'b1, tbc;

    tec_timer dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .address_i(address_i), .read_i(read_i), .write_i(write_i),
        .writedata_i(writedata_i), .byteenable_i(byteenable_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .ext_timer_pin_i(pin), .low_freq_crystal_clock_i(lfxt),
        .pwm_enable_i(pwm_en), .sleep_i(sleep), .overflow_o(overflow_o),
        .wakeup_o(wakeup_o), .timer_base_clock_o(tbc));
    tec_pin_source src (.ref_clk_i(ref_clk_i), .start_i(src_start),
        .toggles_i(src_toggles), .half_i(8'h28), .pin_o(pin),
        .busy_o(src_busy));

    // ****************************************************************
    // Clocks and event counters
    // ****************************************************************
    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end
    // Crystal falls once every 20 system cycles
    always @(posedge ref_clk_i) begin
        if (xtal_div == 9) begin
            xtal_div <= 0;
            lfxt <= ~lfxt;
        end else begin
            xtal_div <= xtal_div + 1;
        end
    end
    always @(negedge ref_clk_i) begin
        if (overflow_o === 1'b1) ovf_cnt++;
        if (wakeup_o === 1'b1) wake_cnt++;
        if (tbc === 1'b1) tbc_cnt++;
    end

    // ****************************************************************
    // Common tasks
    // ****************************************************************
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic give_up;
        mismatches++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 0, 1);
        complete_run;
    endtask
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [7:0] wd, input logic [3:0] be);
        int n;
        @(posedge ref_clk_i);
        address_i <= a;
        writedata_i <= {24'h0, wd};
        byteenable_i <= be;
        write_i <= wr;
        read_i <= ~wr;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 50);
        d = readdata_o;
        write_i <= 1'b0;
        read_i <= 1'b0;
        if (n >= 50) give_up;
    endtask
    task automatic wait_ovf(output int n);
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (overflow_o !== 1'b1 && n < 3000);
        if (n >= 3000) give_up;
    endtask
    task automatic ovf_gap(output int n);
        wait_ovf(n);
        wait_ovf(n);
    endtask
    task automatic setup(input logic [7:0] cnt, input logic [7:0] ctrl);
        bus(1'b1, tec_pkg::OFS_CONTROL, ctrl & 8'hEF, 4'h1);
        bus(1'b1, tec_pkg::OFS_COUNT, cnt, 4'h1);
        bus(1'b1, tec_pkg::OFS_CONTROL, ctrl, 4'h1);
    endtask
    task automatic pin_toggles(input logic [7:0] k);
        int n;
        @(posedge ref_clk_i);
        src_toggles <= k;
        src_start <= 1'b1;
        @(posedge ref_clk_i);
        src_start <= 1'b0;
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (src_busy !== 1'b0 && n < 3000);
        if (n >= 3000) give_up;
        repeat (8) @(posedge ref_clk_i);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_regs;
        bus(1'b0, tec_pkg::OFS_CONTROL, 8'h00, 4'h0);
        `CHK(d, {24'h0, tec_pkg::CTRL_RESET})
        bus(1'b1, tec_pkg::OFS_T1_COUNT, 8'hA5, 4'h1);
        bus(1'b1, tec_pkg::OFS_T1_COUNT, 8'h5A, 4'h0);
        bus(1'b0, tec_pkg::OFS_T1_COUNT, 8'h00, 4'h0);
        `CHK(d, 32'h0000_00A5)
        bus(1'b1, 4'hC, 8'h33, 4'h1);
        bus(1'b0, 4'hC, 8'h00, 4'h0);
        `CHK(d, 32'h0)
        setup(8'h3C, 8'h80);
        bus(1'b0, tec_pkg::OFS_COUNT, 8'h00, 4'h0);
        `CHK(d, 32'h0000_003C)
        $display("test_regs done");
    endtask
    task automatic test_hold;
        int o;
        logic [7:0] ctl [2] = '{8'h82, 8'h10};
        for (int i = 0; i < 2; i++) begin
            setup(8'h77, ctl[i]);
            o = ovf_cnt;
            repeat (300) @(posedge ref_clk_i);
            bus(1'b0, tec_pkg::OFS_COUNT, 8'h00, 4'h0);
            `CHK(d, 32'h0000_0077)
            `CHK(ovf_cnt - o, 0)
        end
        $display("test_hold done");
    endtask
    task automatic test_presc;
        int n;
        int o;
        for (int p = 0; p < 8; p++) begin
            setup(8'hFD, 8'h90 | p[7:0]);
            ovf_gap(n);
            `CHK(n, 3 << p)
        end
        setup(8'hFD, 8'h90);
        ovf_gap(n);
        `CHK(n, 3)
        bus(1'b1, tec_pkg::OFS_COUNT, 8'hF0, 4'h1);
        wait_ovf(n);
        ovf_gap(n);
        `CHK(n, 16)
        // Clock enable low freezes counter and prescaler alike
        @(posedge ref_clk_i);
        ce <= 1'b0;
        o = ovf_cnt;
        repeat (50) @(posedge ref_clk_i);
        ce <= 1'b1;
        `CHK(ovf_cnt - o, 0)
        wait_ovf(n);
        `CHK(n, 16)
        $display("test_presc done");
    endtask
    task automatic test_clk_src;
        int n;
        int t;
        setup(8'hFD, 8'hB0);
        ovf_gap(n);
        `CHK(n, 60)
        @(posedge ref_clk_i);
        t = tbc_cnt;
        repeat (200) @(posedge ref_clk_i);
        `CHK(tbc_cnt - t, 10)
        @(posedge ref_clk_i);
        pwm_en <= 1'b1;
        ovf_gap(n);
        `CHK(n, 3)
        @(posedge ref_clk_i);
        t = tbc_cnt;
        repeat (100) @(posedge ref_clk_i);
        `CHK(tbc_cnt - t, 100)
        pwm_en <= 1'b0;
        $display("test_clk_src done");
    endtask
    task automatic test_event(input logic e, input logic [7:0] k,
                              input logic [7:0] exp);
        int o, w;
        setup(8'hFE, 8'h50 | {4'h0, e, 3'h0});
        @(posedge ref_clk_i);
        sleep <= 1'b1;
        o = ovf_cnt;
        w = wake_cnt;
        pin_toggles(k);
        bus(1'b0, tec_pkg::OFS_COUNT, 8'h00, 4'h0);
        `CHK(d[7:0], exp)
        `CHK(ovf_cnt - o, 1)
        `CHK(wake_cnt - w, 1)
        sleep <= 1'b0;
        $display("test_event done");
    endtask
    task automatic test_capture(input logic e);
        setup(8'h00, 8'hD0 | {4'h0, e, 3'h0});
        repeat (20) @(posedge ref_clk_i);
        bus(1'b0, tec_pkg::OFS_COUNT, 8'h00, 4'h0);
        `CHK(d[7:0], 8'h00)
        pin_toggles(8'h02);
        bus(1'b0, tec_pkg::OFS_COUNT, 8'h00, 4'h0);
        `CHK(d[7:0] >= 8'h27 && d[7:0] <= 8'h29, 1'b1)
        bus(1'b0, tec_pkg::OFS_CONTROL, 8'h00, 4'h0);
        `CHK(d[7:0], 8'hC0 | {4'h0, e, 3'h0})
        $display("test_capture done");
    endtask
    // Mid-run reset: control returns to default, preload survives
    task automatic test_reset;
        int n;
        setup(8'h5A, 8'h80);
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        bus(1'b0, tec_pkg::OFS_CONTROL, 8'h00, 4'h0);
        `CHK(d, {24'h0, tec_pkg::CTRL_RESET})
        bus(1'b1, tec_pkg::OFS_CONTROL, 8'h90, 4'h1);
        ovf_gap(n);
        `CHK(n, 166)
        $display("test_reset done");
    endtask

    initial begin
        repeat (6) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        test_regs;
        test_hold;
        test_presc;
        test_clk_src;
        test_event(1'b0, 8'h05, 8'hFF);
        test_event(1'b1, 8'h04, 8'hFE);
        test_capture(1'b0);
        pin_toggles(8'h01);
        test_capture(1'b1);
        test_reset;
        complete_run;
    end
endmodule
